/* regs_map.svh */
// Register offsets, field positions, reset values and timing counts for the
// linear-regulator mask and load-current measurement register slice.
// Assumes an 8-bit register port with 8-bit addresses driven by the serial front end.
`ifndef REGS_MAP_SVH
`define REGS_MAP_SVH

`define OFS_LINREG_IRQ_MASK     8'h23
`define OFS_LOAD_MEAS_SELECT    8'h24
`define OFS_LOAD_CURRENT_HIGH   8'h25
`define OFS_LOAD_CURRENT_LOW    8'h26

`define BIT_LINREG1_PG_INVALID  7
`define BIT_LINREG1_PG_VALID    6
`define BIT_LINREG1_CURLIMIT    4
`define BIT_LINREG0_PG_INVALID  3
`define BIT_LINREG0_PG_VALID    2
`define BIT_LINREG0_CURLIMIT    0
`define LINREG_MASK_WR_BITS     8'hDD
`define RST_LINREG_IRQ_MASK     8'hCC
`define RST_LOAD_MEAS_SELECT    8'h00
`define RST_LOAD_CURRENT        9'h000
`define RST_MEAS_READY_MASK     1'b0

`define MEAS_TIME_NS            1000
`define CLK_PERIOD_NS           8
`define MEAS_CYCLES             ((`MEAS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* regs_pkg.sv */
// Types shared by the register slice and its result holder.
// Assumes regs_map.svh supplies all numeric constants.
package regs_pkg;
	typedef enum logic [1:0] {MEAS_IDLE, MEAS_BUSY, MEAS_DONE} meas_state_e;
	typedef logic [8:0] current_t;
endpackage : regs_pkg

/* result_hold.sv */
// Holds the last completed 9-bit load-current result.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/1ps
`include "regs_map.svh"
module result_hold
	import regs_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     rst_n_in,
	input  wire logic     load_in,
	input  wire current_t data_in,
	output current_t      data_out
);
	// Both halves captured in one edge; the host's high and low reads are separate, so a capture between them gives a torn value
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			data_out <= `RST_LOAD_CURRENT;
		else if (load_in)
			data_out <= data_in;
	end

	a_hold_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!load_in |=> $stable(data_out)) else $error("result changed without load");
endmodule : result_hold

/* linreg_load_regs.sv */
// Linear-regulator interrupt masks and buck load-current measurement registers.
// Assumes an 8-bit register port, status/events from the analog side asynchronous to MCLK_IN,
// and a measurement engine that answers a start pulse with a done pulse and value.
`timescale 1ns/1ps
`include "regs_map.svh"
module linreg_load_regs
	import regs_pkg::*;
#(
	parameter int MEAS_CYCLES = `MEAS_CYCLES
)(
	input  wire logic       MCLK_IN,
	input  wire logic       RST_N_IN,
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire logic [7:0] REG_WDATA_IN,
	input  wire logic       REG_WR_IN,
	input  wire logic       REG_RD_IN,
	input  wire logic [1:0] LINREG_PG_IN,
	input  wire logic [1:0] LINREG_CURLIMIT_IN,
	input  wire logic       MEAS_READY_MASK_IN,
	input  wire logic       MEAS_DONE_IN,
	input  wire current_t   MEAS_VALUE_IN,
	output logic [7:0]      REG_RDATA_OUT,
	output logic            MEAS_START_OUT,
	output logic            MEAS_BUCK_SEL_OUT,
	output logic [3:0]      LINREG_LIVE_STATUS_OUT,
	output logic [3:0]      LINREG_IRQ_FLAGS_OUT,
	output logic            MEAS_READY_IRQ_FLAG_OUT,
	output logic            MEAS_BUSY_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: three stages, change accepted when stages 2 and 3 agree

	logic [3:0] sync1_r, sync2_r, sync3_r, live_r;
	wire  [3:0] raw_in = {LINREG_CURLIMIT_IN, LINREG_PG_IN};
	// Pins idle low, so the zero reset of every stage raises no false edge
	wire  [3:0] live_nxt = (sync2_r == sync3_r) ? sync3_r : live_r;

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sync3_r <= 4'h0;
			live_r  <= 4'h0;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			live_r  <= live_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Register decode

	// Address match shared by the write strobes and the read mux
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : addr_hit

	wire wr_mask = REG_WR_IN && addr_hit(REG_ADDR_IN, `OFS_LINREG_IRQ_MASK);
	wire wr_sel  = REG_WR_IN && addr_hit(REG_ADDR_IN, `OFS_LOAD_MEAS_SELECT);

	logic [7:0] mask_r;
	logic [7:0] sel_r;
	logic       ready_mask_r;

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			mask_r       <= `RST_LINREG_IRQ_MASK;
			sel_r        <= `RST_LOAD_MEAS_SELECT;
			ready_mask_r <= `RST_MEAS_READY_MASK;
		end else begin
			ready_mask_r <= MEAS_READY_MASK_IN;
			if (wr_mask)
				mask_r <= REG_WDATA_IN & `LINREG_MASK_WR_BITS;
			if (wr_sel)
				sel_r <= REG_WDATA_IN;
		end
	end

	wire linreg1_pg_invalid_mask = mask_r[`BIT_LINREG1_PG_INVALID];
	wire linreg1_pg_valid_mask   = mask_r[`BIT_LINREG1_PG_VALID];
	wire linreg1_curlimit_mask   = mask_r[`BIT_LINREG1_CURLIMIT];
	wire linreg0_pg_invalid_mask = mask_r[`BIT_LINREG0_PG_INVALID];
	wire linreg0_pg_valid_mask   = mask_r[`BIT_LINREG0_PG_VALID];
	wire linreg0_curlimit_mask   = mask_r[`BIT_LINREG0_CURLIMIT];

////////////////////////////////////////////////////////////////////////////////
// Event detection and interrupt flags
// Live bits order: {linreg1_curlimit, linreg0_curlimit, linreg1_pg, linreg0_pg}

	logic [3:0] prev_r;
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN)
			prev_r <= 4'h0;
		else
			prev_r <= live_r;
	end

	wire rise0_pg = live_r[0] & ~prev_r[0];
	wire fall0_pg = ~live_r[0] & prev_r[0];
	wire rise1_pg = live_r[1] & ~prev_r[1];
	wire fall1_pg = ~live_r[1] & prev_r[1];
	wire rise0_il = live_r[2] & ~prev_r[2];
	wire rise1_il = live_r[3] & ~prev_r[3];

	wire set0_pg = (fall0_pg & ~linreg0_pg_invalid_mask)
	             | (rise0_pg & ~linreg0_pg_valid_mask);
	wire set1_pg = (fall1_pg & ~linreg1_pg_invalid_mask)
	             | (rise1_pg & ~linreg1_pg_valid_mask);
	wire set0_il = rise0_il & ~linreg0_curlimit_mask;
	wire set1_il = rise1_il & ~linreg1_curlimit_mask;

	// Flags are sticky; clearing belongs to the flag register outside this slice
	logic [3:0] flags_r;
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN)
			flags_r <= 4'h0;
		else
			flags_r <= flags_r | {set1_il, set0_il, set1_pg, set0_pg};
	end

////////////////////////////////////////////////////////////////////////////////
// Measurement sequencing

	// Longest wait from a start to its capture when the engine stays silent
	localparam int MEAS_LIMIT = MEAS_CYCLES;
	meas_state_e state_r, state_nxt;
	logic [15:0] cnt_r;
	logic        start_r;
	logic        ready_r;
	logic        capture;
	current_t    result;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			MEAS_IDLE: if (wr_sel) state_nxt = MEAS_BUSY;
			MEAS_BUSY: if (MEAS_DONE_IN || cnt_r == 16'(MEAS_CYCLES - 1)) state_nxt = MEAS_DONE;
			MEAS_DONE: state_nxt = wr_sel ? MEAS_BUSY : MEAS_IDLE;
			default:   state_nxt = MEAS_IDLE;
		endcase
		// A rewrite while busy restarts the measurement
		if (wr_sel) state_nxt = MEAS_BUSY;
	end

	// Engine done pulse is preferred; the timeout is a fallback so a stuck engine still
	// completes the sequence with whatever value it presents.
	assign capture = (state_r == MEAS_BUSY) && !wr_sel
	              && (MEAS_DONE_IN || cnt_r == 16'(MEAS_CYCLES - 1));

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			state_r <= MEAS_IDLE;
			cnt_r   <= 16'h0000;
			start_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (wr_sel || state_r != MEAS_BUSY) ? 16'h0000 : cnt_r + 16'h0001;
			start_r <= wr_sel;
			ready_r <= ready_r | (capture & ~ready_mask_r);
		end
	end

	result_hold u_hold (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.load_in  (capture),
		.data_in  (MEAS_VALUE_IN),
		.data_out (result)
	);

////////////////////////////////////////////////////////////////////////////////
// Read mux

	// Reserved and unmapped locations read zero
	wire [7:0] rd_nxt =
		addr_hit(REG_ADDR_IN, `OFS_LINREG_IRQ_MASK)   ? mask_r :
		addr_hit(REG_ADDR_IN, `OFS_LOAD_MEAS_SELECT)  ? sel_r :
		addr_hit(REG_ADDR_IN, `OFS_LOAD_CURRENT_HIGH) ? {7'h00, result[8]} :
		addr_hit(REG_ADDR_IN, `OFS_LOAD_CURRENT_LOW)  ? result[7:0] :
		8'h00;

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN)
			REG_RDATA_OUT <= 8'h00;
		else if (REG_RD_IN)
			REG_RDATA_OUT <= rd_nxt;
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			MEAS_START_OUT          <= 1'b0;
			MEAS_BUCK_SEL_OUT       <= 1'b0;
			LINREG_LIVE_STATUS_OUT  <= 4'h0;
			LINREG_IRQ_FLAGS_OUT    <= 4'h0;
			MEAS_READY_IRQ_FLAG_OUT <= 1'b0;
			MEAS_BUSY_OUT           <= 1'b0;
		end else begin
			MEAS_START_OUT          <= start_r;
			MEAS_BUCK_SEL_OUT       <= sel_r[0];
			LINREG_LIVE_STATUS_OUT  <= live_r;
			LINREG_IRQ_FLAGS_OUT    <= flags_r;
			MEAS_READY_IRQ_FLAG_OUT <= ready_r;
			MEAS_BUSY_OUT           <= (state_r == MEAS_BUSY);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Checks

	a_reserved_mask_zero: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		mask_r[5] == 1'b0 && mask_r[1] == 1'b0) else $error("reserved mask bit set");
	a_masked_pg1_quiet: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(fall1_pg && linreg1_pg_invalid_mask && !flags_r[1]) |=> !flags_r[1])
		else $error("masked linreg1 pg loss set flag");
	a_pg1_valid_sets: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise1_pg && !linreg1_pg_valid_mask) |=> flags_r[1]) else $error("pg1 rise lost");
	a_il1_sets: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise1_il && !linreg1_curlimit_mask) |=> flags_r[3]) else $error("il1 lost");
	a_pg0_invalid_sets: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(fall0_pg && !linreg0_pg_invalid_mask) |=> flags_r[0]) else $error("pg0 loss lost");
	a_pg0_valid_sets: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise0_pg && !linreg0_pg_valid_mask) |=> flags_r[0]) else $error("pg0 rise lost");
	a_il0_sets: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise0_il && !linreg0_curlimit_mask) |=> flags_r[2]) else $error("il0 lost");
	a_status_follows: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		1'b1 |=> LINREG_LIVE_STATUS_OUT == $past(live_r)) else $error("status not live");
	sequence s_sel_write;
		wr_sel;
	endsequence
	a_write_starts: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		s_sel_write |=> start_r ##1 MEAS_START_OUT) else $error("write did not start");
	a_sel_stored: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		wr_sel |=> sel_r == $past(REG_WDATA_IN)) else $error("select not stored");
	a_high_upper_zero: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_RD_IN && REG_ADDR_IN == `OFS_LOAD_CURRENT_HIGH) |=> REG_RDATA_OUT[7:1] == 7'h00)
		else $error("high result upper bits nonzero");
	a_low_read: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_RD_IN && REG_ADDR_IN == `OFS_LOAD_CURRENT_LOW) |=> REG_RDATA_OUT == $past(result[7:0]))
		else $error("low result read wrong");
	a_ready_raise: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(capture && !ready_mask_r) |=> ##1 MEAS_READY_IRQ_FLAG_OUT) else $error("ready not raised");
	a_result_capture: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		capture |=> result == $past(MEAS_VALUE_IN)) else $error("result not captured whole");

	// Masked events must leave a clear flag clear
	a_pg1_rise_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise1_pg && linreg1_pg_valid_mask && !flags_r[1]) |=> !flags_r[1])
		else $error("masked linreg1 pg gain set flag");
	a_il1_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise1_il && linreg1_curlimit_mask && !flags_r[3]) |=> !flags_r[3])
		else $error("masked linreg1 current limit set flag");
	a_pg0_loss_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(fall0_pg && linreg0_pg_invalid_mask && !flags_r[0]) |=> !flags_r[0])
		else $error("masked linreg0 pg loss set flag");
	a_pg0_rise_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise0_pg && linreg0_pg_valid_mask && !flags_r[0]) |=> !flags_r[0])
		else $error("masked linreg0 pg gain set flag");
	a_il0_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(rise0_il && linreg0_curlimit_mask && !flags_r[2]) |=> !flags_r[2])
		else $error("masked linreg0 current limit set flag");
	a_mask_read_back: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_RD_IN && REG_ADDR_IN == `OFS_LINREG_IRQ_MASK) |=> REG_RDATA_OUT == $past(mask_r))
		else $error("mask read back wrong");
	a_buck_sel_follows: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		1'b1 |=> MEAS_BUCK_SEL_OUT == $past(sel_r[0])) else $error("buck select not driven");
	a_high_msb_read: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_RD_IN && REG_ADDR_IN == `OFS_LOAD_CURRENT_HIGH)
		|=> REG_RDATA_OUT[0] == $past(result[8])) else $error("high result msb wrong");
	a_ro_write_ignored: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_WR_IN && REG_ADDR_IN == `OFS_LOAD_CURRENT_LOW && !capture) |=> $stable(result))
		else $error("write reached read-only result");
	a_unmapped_read_zero: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(REG_RD_IN && REG_ADDR_IN > `OFS_LOAD_CURRENT_LOW) |=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped read nonzero");
	a_ready_masked_quiet: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(capture && ready_mask_r && !ready_r) |=> !ready_r) else $error("masked ready raised");

	// A rewrite restarts the window, so the bound counts from the latest write
	sequence s_meas_end;
		capture || wr_sel;
	endsequence
	a_meas_bounded: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		s_sel_write |-> ##[1:MEAS_LIMIT] s_meas_end) else $error("measurement never ended");
endmodule : linreg_load_regs

/* meas_engine_model.sv */
// Behavioural load-current measurement engine facing the register slice.
// Assumes a one-cycle start pulse and that the slice samples the value with done.
// Mute makes the engine count starts without ever answering them, so the slice's own timeout gets exercised.
`timescale 1ns/1ps
module meas_engine_model
	import regs_pkg::*;
#(
	parameter int DELAY = 3
)(
	input  wire logic clk_in,
	input  wire logic start_in,
	input  wire logic sel_in,
	input  wire logic mute_in,
	output logic      done_out,
	output current_t  value_out,
	output int        starts_out
);
	logic [3:0] cnt_r;
	initial begin
		done_out = 1'b0;
		value_out = 9'h1FF;
		starts_out = 0;
		cnt_r = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Value is only good while done is high; otherwise it toggles so stale data shows
	always @(posedge clk_in) begin
		done_out <= (cnt_r == 4'h1);
		value_out <= (cnt_r == 4'h1) ? (sel_in ? 9'h0F3 : 9'h1A5) : ~value_out;
		if (start_in) begin
			starts_out <= starts_out + 1;
			cnt_r <= mute_in ? 4'h0 : 4'(DELAY);
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule : meas_engine_model

/* tb_top.sv */
// Self-checking bench for the regulator mask and load-current register slice.
// Assumes the strobe register port of the slice and the engine model above.
`timescale 1ns/1ps
module tb_top;
	import regs_pkg::*;
	logic       mclk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, rmask = 1'b1;
	logic       mute = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] pg = 2'b00, il = 2'b00;
	logic       start, sel, done, rflag, busy;
	logic [3:0] live, flags;
	current_t   value;
	int         starts, err_count = 0, tests_run = 0, cycles = 0;
	linreg_load_regs #(.MEAS_CYCLES(40)) dut (.MCLK_IN(mclk_in), .RST_N_IN(rst_n_in),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.LINREG_PG_IN(pg), .LINREG_CURLIMIT_IN(il), .MEAS_READY_MASK_IN(rmask),
		.MEAS_DONE_IN(done), .MEAS_VALUE_IN(value), .REG_RDATA_OUT(rdata),
		.MEAS_START_OUT(start), .MEAS_BUCK_SEL_OUT(sel), .LINREG_LIVE_STATUS_OUT(live),
		.LINREG_IRQ_FLAGS_OUT(flags), .MEAS_READY_IRQ_FLAG_OUT(rflag), .MEAS_BUSY_OUT(busy));
	meas_engine_model eng (.clk_in(mclk_in), .start_in(start), .sel_in(sel), .mute_in(mute),
		.done_out(done), .value_out(value), .starts_out(starts));
	initial begin
		forever #4 mclk_in = ~mclk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		{wr, addr, wdata} = {1'b1, a, d};
		@(negedge mclk_in);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk_in);
		{rd, addr} = {1'b1, a};
		@(negedge mclk_in);
		rd = 1'b0;
		@(negedge mclk_in);
		check($sformatf("reg %h", a), {1'b0, exp}, {1'b0, rdata});
	endtask : rd_chk
	// Start a measurement and wait, bounded, until the engine has counted the start and the slice is no longer busy
	task automatic measure(input logic [7:0] d, input int n);
		int i;
		wr_reg(8'h24, d);
		for (i = 0; i < 60 && !(starts == n && busy === 1'b0); i++) @(negedge mclk_in);
		repeat (3) @(negedge mclk_in);
		check("start count", 9'(n), 9'(starts));
		check("busy done", 9'h0, {8'h0, busy});
	endtask : measure
	task automatic status(input logic [1:0] p, input logic [1:0] c, input logic [3:0] f);
		{pg, il} = {p, c};
		repeat (10) @(negedge mclk_in);
		check("live", {5'h0, c, p}, {5'h0, live});
		check("flags", {5'h0, f}, {5'h0, flags});
	endtask : status
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge mclk_in);
		rst_n_in = 1'b1;
		rd_chk(8'h23, 8'hCC);
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h25, 8'h00);
		rd_chk(8'h30, 8'h00);
		measure(8'h01, 1);
		check("buck sel", 9'h1, {8'h0, sel});
		check("ready masked", 9'h0, {8'h0, rflag});
		rd_chk(8'h25, 8'h00);
		rd_chk(8'h26, 8'hF3);
		wr_reg(8'h26, 8'h55);
		rd_chk(8'h26, 8'hF3);
		measure(8'h00, 2);
		rd_chk(8'h25, 8'h01);
		rd_chk(8'h26, 8'hA5);
		rmask = 1'b0;
		measure(8'hFE, 3);
		check("ready flag", 9'h1, {8'h0, rflag});
		check("buck sel", 9'h0, {8'h0, sel});
		rd_chk(8'h24, 8'hFE);
		mute = 1'b1;
		measure(8'h01, 4);
		mute = 1'b0;
		wr_reg(8'h24, 8'h00);
		measure(8'h01, 6);
		rd_chk(8'h25, 8'h00);
		rd_chk(8'h26, 8'hF3);
		wr_reg(8'h23, 8'hFF);
		rd_chk(8'h23, 8'hDD);
		status(2'b11, 2'b11, 4'h0);
		status(2'b00, 2'b00, 4'h0);
		wr_reg(8'h23, 8'h00);
		status(2'b01, 2'b00, 4'h1);
		wr_reg(8'h23, 8'h40);
		status(2'b11, 2'b00, 4'h1);
		status(2'b01, 2'b00, 4'h3);
		wr_reg(8'h23, 8'h01);
		status(2'b01, 2'b01, 4'h3);
		status(2'b01, 2'b10, 4'hB);
		status(2'b00, 2'b00, 4'hB);
		rst_n_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		rst_n_in = 1'b1;
		check("flags reset", 9'h0, {5'h0, flags});
		check("ready reset", 9'h0, {8'h0, rflag});
		rd_chk(8'h23, 8'hCC);
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h26, 8'h00);
		wr_reg(8'h23, 8'h04);
		status(2'b01, 2'b00, 4'h0);
		status(2'b00, 2'b00, 4'h1);
		status(2'b10, 2'b00, 4'h3);
		finish_test();
	end
endmodule : tb_top
